/* rts_params.svh */
`ifndef RTS_PARAMS_SVH
`define RTS_PARAMS_SVH

`define RTS_SRC_FMT_BIT   15
`define RTS_DST_MOD_LSB   8
`define RTS_DST_SUB_LSB   12
`define RTS_PFX_DST_LSB   0
`define RTS_PFX_SRC_BIT   4

`define RTS_PFX_MOD       4'hB
`define RTS_PFX_IDX       5'h00
`define RTS_IP_MOD        4'hC
`define RTS_IP_IDX        5'h00
`define RTS_SPE_MOD       4'h8
`define RTS_SPE_IDX       5'h08

`define RTS_IP_RST        16'h8000
`define RTS_PFX_RST       8'h00
`define RTS_SPE_RST       1'b0
`define RTS_PERIPH_LAST   4'h5

`define RTS_DEF_MASK      32'h00FF_FFFF
`define RTS_WIDE_MODS     16'hFFC0
`define RTS_SETTLE_CNT    2'h3

`endif

/* rts_pkg.sv */
package rts_pkg;

	typedef logic [15:0] rts_word_t;
	typedef logic [7:0]  rts_byte_t;
	typedef logic [3:0]  rts_mod_t;
	typedef logic [4:0]  rts_idx_t;
	typedef logic [8:0]  rts_addr_t;

	typedef enum logic [2:0] {
		RTS_ST_SETTLE = 3'b001,
		RTS_ST_SAMPLE = 3'b010,
		RTS_ST_RUN    = 3'b100
	} rts_state_t;

endpackage

/* rts_reg_mem.sv */
`timescale 1ns/1ps
`default_nettype none

module rts_reg_mem #(
	parameter int AW = 9,
	parameter int DW = 16
) (
	input  wire logic          mclk,
	input  wire logic          rst_n,
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata_q,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata
);

	logic [DW-1:0] mem_q [0:(1<<AW)-1];
	logic [DW-1:0] rdata_d;

	// write-first so a move reading what the previous move writes sees it
	assign rdata_d = (we && (waddr == raddr)) ? wdata : mem_q[raddr];

	always_ff @(posedge mclk) begin
		if (we) begin
			mem_q[waddr] <= wdata;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

endmodule

`default_nettype wire

/* rts_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rts_params.svh"

module rts_core #(
	parameter logic [31:0] DEF_MASK  = `RTS_DEF_MASK,
	parameter logic [15:0] WIDE_MODS = `RTS_WIDE_MODS
) (
	input  wire logic               mclk,
	input  wire logic               rst_n,
	output logic                    fetch_req,
	output var rts_pkg::rts_word_t  fetch_addr,
	input  wire logic               fetch_ack,
	input  wire rts_pkg::rts_word_t fetch_instr,
	input  wire logic               spe_pin,
	output logic                    boot_sel,
	output logic                    src_rd_pulse,
	output var rts_pkg::rts_mod_t   src_rd_mod,
	output var rts_pkg::rts_idx_t   src_rd_idx,
	output logic                    src_rd_periph,
	output logic                    dst_wr_pulse,
	output var rts_pkg::rts_mod_t   dst_wr_mod,
	output var rts_pkg::rts_idx_t   dst_wr_idx,
	output var rts_pkg::rts_word_t  dst_wr_data,
	output logic                    move_dummy,
	output var rts_pkg::rts_byte_t  transfer_prefix
);

	import rts_pkg::*;

	// location decode helpers
	function automatic logic is_loc(
		input rts_mod_t m,
		input rts_idx_t i,
		input rts_mod_t lm,
		input rts_idx_t li
	);
		return (m == lm) && (i == li);
	endfunction

	function automatic logic reg_def(
		input rts_mod_t m,
		input rts_idx_t i
	);
		return DEF_MASK[i]
			|| is_loc(m, i, `RTS_PFX_MOD, `RTS_PFX_IDX)
			|| is_loc(m, i, `RTS_IP_MOD, `RTS_IP_IDX)
			|| is_loc(m, i, `RTS_SPE_MOD, `RTS_SPE_IDX);
	endfunction

	function automatic logic reg_wide(
		input rts_mod_t m,
		input rts_idx_t i
	);
		return WIDE_MODS[m]
			&& !is_loc(m, i, `RTS_PFX_MOD, `RTS_PFX_IDX)
			&& !is_loc(m, i, `RTS_SPE_MOD, `RTS_SPE_IDX);
	endfunction

	// a module holding any 8-bit register counts as narrow
	function automatic logic mod_narrow(
		input rts_mod_t m
	);
		return !WIDE_MODS[m]
			|| (m == `RTS_PFX_MOD)
			|| (m == `RTS_SPE_MOD);
	endfunction

	// state
	rts_state_t state_q;
	rts_state_t state_d;
	logic [1:0] settle_q;
	logic [1:0] settle_d;

	logic       spe_s1_q;
	logic       spe_s2_q;
	logic       spe_s3_q;
	logic       spe_stable;
	logic       spe_q;
	logic       spe_d;

	rts_word_t  ip_q;
	rts_word_t  ip_d;
	rts_byte_t  pfx_q;
	rts_byte_t  pfx_d;

	// stage 0: instruction just fetched
	logic       run;
	logic       fetch_take;
	logic       s0_valid;
	logic       s0_imm;
	rts_byte_t  s0_src;
	rts_mod_t   s0_smod;
	rts_idx_t   s0_sidx;
	rts_mod_t   s0_dmod;
	logic [2:0] s0_dsub;

	// stage 1: move executes
	logic       s1_valid_q;
	logic       s1_imm_q;
	rts_byte_t  s1_src_q;
	rts_mod_t   s1_smod_q;
	rts_idx_t   s1_sidx_q;
	rts_mod_t   s1_dmod_q;
	logic [2:0] s1_dsub_q;

	rts_word_t  mem_rdata;
	rts_idx_t   s1_didx;
	logic       src_def;
	logic       src_wide;
	logic       src_is8;
	rts_word_t  src_raw;
	rts_word_t  src_val;
	logic       dst_def;
	logic       dst_wide;
	rts_word_t  wdata;
	logic       wr;
	logic       pfx_wr;
	logic       ip_wr;
	logic       spe_wr;
	logic       mem_we;

	// start-up sequencing and pin capture

	assign spe_stable = (spe_s2_q == spe_s3_q);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			spe_s1_q <= 1'b0;
			spe_s2_q <= 1'b0;
			spe_s3_q <= 1'b0;
		end else begin
			spe_s1_q <= spe_pin;
			spe_s2_q <= spe_s1_q;
			spe_s3_q <= spe_s2_q;
		end
	end

	// fetch waits until the strap is sampled, so the startup code sees it
	always_comb begin
		state_d  = state_q;
		settle_d = settle_q;
		case (state_q)
		RTS_ST_SETTLE: begin
			settle_d = settle_q + 2'h1;
			if (settle_q == `RTS_SETTLE_CNT) begin
				state_d = RTS_ST_SAMPLE;
			end
		end
		RTS_ST_SAMPLE: begin
			if (spe_stable) begin
				state_d = RTS_ST_RUN;
			end
		end
		RTS_ST_RUN: begin
			state_d = RTS_ST_RUN;
		end
		default: begin
			state_d = RTS_ST_SETTLE;
		end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q  <= RTS_ST_SETTLE;
			settle_q <= 2'h0;
		end else begin
			state_q  <= state_d;
			settle_q <= settle_d;
		end
	end

	// the test port request is taken once; later only software changes it
	assign spe_d = ((state_q == RTS_ST_SAMPLE) && spe_stable) ? spe_s3_q :
		spe_wr ? wdata[0] : spe_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			spe_q <= `RTS_SPE_RST;
		end else begin
			spe_q <= spe_d;
		end
	end

	assign boot_sel = spe_q;

	// program fetch

	assign run        = (state_q == RTS_ST_RUN);
	assign fetch_req  = run;
	assign fetch_addr = ip_q;
	assign fetch_take = fetch_req && fetch_ack;

	// an instruction fetched while a pointer write lands is a stale path
	assign s0_valid = fetch_take && !ip_wr;

	assign ip_d = ip_wr ? wdata :
		fetch_take ? ip_q + 16'h0001 : ip_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ip_q <= `RTS_IP_RST;
		end else begin
			ip_q <= ip_d;
		end
	end

	// instruction decode
	// pfx_d is exactly the prefix the following move will see

	assign s0_imm  = !fetch_instr[`RTS_SRC_FMT_BIT];
	assign s0_src  = fetch_instr[7:0];
	assign s0_smod = fetch_instr[3:0];
	assign s0_sidx = {pfx_d[`RTS_PFX_SRC_BIT],
		fetch_instr[7:4]};
	assign s0_dmod = fetch_instr[11:8];
	assign s0_dsub = fetch_instr[14:12];

	rts_reg_mem #(
		.AW (9),
		.DW (16)
	) u_mem (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.raddr   ({s0_smod, s0_sidx}),
		.rdata_q (mem_rdata),
		.we      (mem_we),
		.waddr   ({s1_dmod_q, s1_didx}),
		.wdata   (wdata)
	);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s1_valid_q <= 1'b0;
			s1_imm_q   <= 1'b0;
			s1_src_q   <= 8'h00;
			s1_smod_q  <= 4'h0;
			s1_sidx_q  <= 5'h00;
			s1_dmod_q  <= 4'h0;
			s1_dsub_q  <= 3'h0;
		end else begin
			s1_valid_q <= s0_valid;
			s1_imm_q   <= s0_imm;
			s1_src_q   <= s0_src;
			s1_smod_q  <= s0_smod;
			s1_sidx_q  <= s0_sidx;
			s1_dmod_q  <= s0_dmod;
			s1_dsub_q  <= s0_dsub;
		end
	end

	// move execution; upper destination indices only reachable via prefix
	assign s1_didx = {pfx_q[`RTS_PFX_DST_LSB +: 2], s1_dsub_q};

	assign src_def  = reg_def(s1_smod_q, s1_sidx_q);
	assign src_wide = reg_wide(s1_smod_q, s1_sidx_q);
	assign dst_def  = reg_def(s1_dmod_q, s1_didx);
	assign dst_wide = reg_wide(s1_dmod_q, s1_didx);

	// reads come straight from storage except the pointer, prefix and enable locations
	assign src_raw =
		is_loc(s1_smod_q, s1_sidx_q, `RTS_IP_MOD, `RTS_IP_IDX) ? ip_q :
		is_loc(s1_smod_q, s1_sidx_q, `RTS_PFX_MOD, `RTS_PFX_IDX) ?
			{8'h00, pfx_q} :
		is_loc(s1_smod_q, s1_sidx_q, `RTS_SPE_MOD, `RTS_SPE_IDX) ?
			{15'h0000, spe_q} :
		mem_rdata;

	assign src_val =
		s1_imm_q ? {8'h00, s1_src_q} :
		!src_def ? (mod_narrow(s1_smod_q) ?
			{pfx_q, 8'h00} :
			16'h0000) :
		src_wide ? src_raw :
		{8'h00, src_raw[7:0]};

	assign src_is8 = s1_imm_q || (src_def && !src_wide);

	assign wdata =
		!dst_wide ? {8'h00, src_val[7:0]} :
		src_is8 ? {pfx_q, src_val[7:0]} :
		src_val;

	// peripheral and system groups share one decode path
	assign wr = s1_valid_q && dst_def;

	assign pfx_wr = wr &&
		is_loc(s1_dmod_q, s1_didx, `RTS_PFX_MOD, `RTS_PFX_IDX);
	assign ip_wr  = wr &&
		is_loc(s1_dmod_q, s1_didx, `RTS_IP_MOD, `RTS_IP_IDX);
	assign spe_wr = wr && run &&
		is_loc(s1_dmod_q, s1_didx, `RTS_SPE_MOD, `RTS_SPE_IDX);
	assign mem_we = wr && !pfx_wr && !ip_wr &&
		!is_loc(s1_dmod_q, s1_didx, `RTS_SPE_MOD, `RTS_SPE_IDX);

	// prefix lives one cycle only, whether or not a move follows
	assign pfx_d = pfx_wr ? wdata[7:0] : 8'h00;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pfx_q <= `RTS_PFX_RST;
		end else begin
			pfx_q <= pfx_d;
		end
	end

	assign transfer_prefix = pfx_q;

	// side effects toward the register modules
	// source strobe fires even for a dummy move, e.g. pointer decrement
	assign src_rd_pulse  = s1_valid_q && !s1_imm_q;
	assign src_rd_mod    = s1_smod_q;
	assign src_rd_idx    = s1_sidx_q;
	assign src_rd_periph = (s1_smod_q <= `RTS_PERIPH_LAST);

	// write strobe is registered: peripherals see it one cycle late
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dst_wr_pulse <= 1'b0;
			dst_wr_mod   <= 4'h0;
			dst_wr_idx   <= 5'h00;
			dst_wr_data  <= 16'h0000;
			move_dummy   <= 1'b0;
		end else begin
			dst_wr_pulse <= wr;
			dst_wr_mod   <= s1_dmod_q;
			dst_wr_idx   <= s1_didx;
			dst_wr_data  <= wdata;
			move_dummy   <= s1_valid_q && !dst_def;
		end
	end

endmodule

`default_nettype wire

/* rts_prog_model.sv */
`timescale 1ns/1ps
`default_nettype none

module rts_prog_model (
	input  wire logic        mclk,
	input  wire logic        fetch_req,
	input  wire logic        stall,
	input  wire logic [15:0] fetch_addr,
	output logic             fetch_ack,
	output logic      [15:0] fetch_instr
);
	logic [15:0] mem [0:65535];
	logic [15:0] last_q = 16'h0000;
	logic        pfx_next_q = 1'b0;

	// one word per address over the whole 16-bit fetch space
	// a prefix load is never split from its target: no stall right after it
	assign fetch_ack = fetch_req && (!stall || pfx_next_q);
	// idle bus shows the inverted last word so a stale sample never matches
	assign fetch_instr = fetch_ack ? mem[fetch_addr] : ~last_q;

	always @(posedge mclk) begin
		pfx_next_q <= fetch_ack && (mem[fetch_addr][14:8] == 7'h0B);
		if (fetch_ack) begin
			last_q <= mem[fetch_addr];
		end
	end
endmodule

`default_nettype wire

/* rts_core_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module rts_core_asserts (
	input wire logic               mclk,
	input wire logic               rst_n,
	input wire logic               fetch_req,
	input wire rts_pkg::rts_word_t fetch_addr,
	input wire logic               fetch_ack,
	input wire rts_pkg::rts_word_t fetch_instr,
	input wire logic               spe_pin,
	input wire logic               boot_sel,
	input wire logic               src_rd_pulse,
	input wire rts_pkg::rts_mod_t  src_rd_mod,
	input wire rts_pkg::rts_idx_t  src_rd_idx,
	input wire logic               src_rd_periph,
	input wire logic               dst_wr_pulse,
	input wire rts_pkg::rts_mod_t  dst_wr_mod,
	input wire rts_pkg::rts_idx_t  dst_wr_idx,
	input wire rts_pkg::rts_word_t dst_wr_data,
	input wire logic               move_dummy,
	input wire rts_pkg::rts_byte_t transfer_prefix
);
	import rts_pkg::*;
	logic      ipw;
	rts_byte_t jlo_q;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// accepted write of the instruction pointer, immediate or register source (no prefix)
	assign ipw = fetch_req && fetch_ack && fetch_instr[14:8] == 7'h0C;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			jlo_q <= 8'h00;
		end else if (ipw) begin
			jlo_q <= fetch_instr[7:0];
		end
	end

	chk_ip_reset: assert property (
		$rose(rst_n) |-> fetch_addr == 16'h8000)
		else $error("fetch address not at reset vector");
	chk_pfx_reset: assert property (
		$rose(rst_n) |-> transfer_prefix == 8'h00)
		else $error("prefix not clear after reset");
	chk_spe_reset: assert property (
		$rose(rst_n) |-> !boot_sel)
		else $error("programming enable set too early");
	// squashed slots are left out: their address step is not defined
	chk_ip_step: assert property (
		fetch_req && !ipw && !$past(ipw) |=>
		fetch_addr == $past(fetch_addr) + {15'h0000, $past(fetch_ack)})
		else $error("instruction pointer step wrong");
	chk_ip_jump: assert property (
		ipw && !fetch_instr[15] |-> ##[1:2] fetch_addr[7:0] == jlo_q)
		else $error("fetch not redirected");
	// nonzero only in the cycle its own write stands, so back to back is legal
	chk_pfx_clear: assert property (
		transfer_prefix != 8'h00 |-> dst_wr_pulse
		&& dst_wr_mod == 4'hB && dst_wr_idx == 5'h00)
		else $error("prefix held too long");
	chk_src_kind: assert property (
		fetch_req && fetch_ack && !$past(ipw) |=>
		src_rd_pulse == $past(fetch_instr[15]))
		else $error("source kind decode wrong");
	chk_src_fields: assert property (
		fetch_req && fetch_ack && fetch_instr[15] && !$past(ipw) |=>
		src_rd_mod == $past(fetch_instr[3:0])
		&& src_rd_idx[3:0] == $past(fetch_instr[7:4]))
		else $error("source field decode wrong");
	chk_src_group: assert property (
		src_rd_pulse |-> src_rd_periph == (src_rd_mod <= 4'h5))
		else $error("peripheral group flag wrong");
	chk_narrow_dest: assert property (
		dst_wr_pulse && dst_wr_mod <= 4'h5 |-> dst_wr_data[15:8] == 8'h00)
		else $error("narrow register upper bits set");
	// with the default map only indices 24 to 31 are undefined
	chk_dummy_store: assert property (
		move_dummy |-> !dst_wr_pulse && dst_wr_idx[4:3] == 2'b11)
		else $error("undefined destination stored");
endmodule

bind rts_core rts_core_asserts u_chk (.mclk, .rst_n, .fetch_req, .fetch_addr,
	.fetch_ack, .fetch_instr, .spe_pin, .boot_sel, .src_rd_pulse, .src_rd_mod,
	.src_rd_idx, .src_rd_periph, .dst_wr_pulse, .dst_wr_mod, .dst_wr_idx,
	.dst_wr_data, .move_dummy, .transfer_prefix);

`default_nettype wire

/* tb_register_transport_space.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_register_transport_space;
	import rts_pkg::*;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        spe_pin = 1'b0;
	logic        stall = 1'b0;
	logic        mon_en = 1'b0;
	logic        fetch_req, fetch_ack, boot_sel, src_rd_pulse;
	logic        src_rd_periph, dst_wr_pulse, move_dummy;
	rts_word_t   fetch_addr, fetch_instr, dst_wr_data;
	rts_mod_t    src_rd_mod, dst_wr_mod;
	rts_idx_t    src_rd_idx, dst_wr_idx;
	rts_byte_t   transfer_prefix;
	logic [31:0] exq [$];
	logic [31:0] sv, ev;
	logic [15:0] pc;
	int          bad_count = 0;
	int          checked = 0;

	always #20 mclk = ~mclk;

	rts_core dut (.mclk, .rst_n, .fetch_req, .fetch_addr, .fetch_ack,
		.fetch_instr, .spe_pin, .boot_sel, .src_rd_pulse, .src_rd_mod,
		.src_rd_idx, .src_rd_periph, .dst_wr_pulse, .dst_wr_mod, .dst_wr_idx,
		.dst_wr_data, .move_dummy, .transfer_prefix);
	rts_prog_model u_prog (.mclk, .fetch_req, .stall, .fetch_addr, .fetch_ack,
		.fetch_instr);

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		if (bad_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	function automatic logic [15:0] mv(logic f, logic [2:0] s, logic [3:0] m,
		logic [7:0] src);
		return {f, s, m, src};
	endfunction

	// width conversion of a move: narrow dest keeps the low byte only
	function automatic logic [15:0] cvt(logic [15:0] v, logic sw, logic dw,
		logic [7:0] pf);
		if (!dw) begin
			return {8'h00, v[7:0]};
		end
		return sw ? v : {pf, v[7:0]};
	endfunction

	task automatic put(input logic [15:0] w);
		u_prog.mem[pc] = w;
		pc = pc + 16'h0001;
	endtask

	task automatic ex(input logic [15:0] w, input logic [3:0] m,
		input logic [4:0] i, input logic [15:0] d);
		put(w);
		exq.push_back({7'h00, m, i, d});
	endtask

	task automatic do_reset(input logic system_programming_enable);
		@(negedge mclk);
		rst_n = 1'b0;
		spe_pin = system_programming_enable;
		repeat (10) @(negedge mclk);
		rst_n = 1'b1;
		for (int n = 0; n < 50 && fetch_req !== 1'b1; n++) begin
			@(negedge mclk);
		end
		if (fetch_req !== 1'b1) begin
			bad_count++;
			tally_and_finish();
		end
		chk("fetch_addr", 32'(fetch_addr), 32'h0000_8000);
		chk("boot_sel", 32'(boot_sel), 32'(system_programming_enable));
		chk("transfer_prefix", 32'(transfer_prefix), 32'h0);
	endtask

	// prefix and jump writes carry no expectation of their own
	always @(negedge mclk) begin
		stall <= ($urandom % 4) == 0;
		if (mon_en && (move_dummy === 1'b1 || (dst_wr_pulse === 1'b1
			&& !(dst_wr_mod inside {4'hB, 4'hC})))) begin
			sv = move_dummy ? 32'h0200_0000 : {7'h00, dst_wr_mod, dst_wr_idx,
				dst_wr_data};
			ev = exq.size() > 0 ? exq.pop_front() : 32'hFFFF_FFFF;
			chk("move", sv, ev);
		end
	end

	initial begin
		logic [7:0]  a, b, p, t;
		logic [15:0] r;
		logic [3:0]  m;
		void'($urandom(32'h1C1126D8));
		a = 8'($urandom);
		b = 8'($urandom);
		p = 8'(($urandom % 63) + 1) << 2;
		pc = 16'h8000;
		ex(mv(0, 1, 0, a), 0, 1, {8'h00, a});
		put({8'h0B, p});
		ex(mv(0, 1, 6, b), 6, 1, cvt(16'(b), 0, 1, p));
		ex(mv(0, 2, 6, b), 6, 2, cvt(16'(b), 0, 1, 8'h00));
		ex(mv(1, 3, 7, 8'h16), 7, 3, cvt({p, b}, 1, 1, 8'h00));
		ex(mv(1, 2, 0, 8'h16), 0, 2, cvt({p, b}, 1, 0, 8'h00));
		ex(mv(1, 0, 1, 8'h10), 1, 0, cvt(16'(a), 0, 0, 8'h00));
		put(16'h0B03);
		put(mv(0, 0, 6, a));
		exq.push_back(32'h0200_0000);
		put(16'h0B03);
		put(mv(1, 0, 6, 8'h16));
		exq.push_back(32'h0200_0000);
		put(16'h0B01);
		ex(mv(0, 1, 6, a), 6, 9, {8'h01, a});
		put(16'h0B02);
		ex(mv(0, 0, 6, a), 6, 16, {8'h02, a});
		put(16'h0B10);
		ex(mv(1, 1, 7, 8'h06), 7, 1, {8'h02, a});
		put(16'h0B10);
		ex(mv(1, 4, 6, 8'h80), 6, 4, 16'h1000);
		put(16'h0B10);
		ex(mv(1, 5, 6, 8'h87), 6, 5, 16'h0000);
		put(mv(0, 0, 4'hC, 8'h40));
		put(mv(0, 0, 1, 8'hEE));
		pc = 16'h0040;
		for (int k = 0; k < 24; k++) begin
			r = 16'($urandom);
			m = r[11:8];
			if (m inside {4'h8, 4'hB, 4'hC}) begin
				m = m ^ 4'h1;
			end
			ex(mv(0, r[14:12], m, r[7:0]), m, {2'b00, r[14:12]},
				cvt(16'(r[7:0]), 0, m > 4'h5, 8'h00));
		end
		t = pc[7:0];
		put(mv(0, 0, 4'hC, t));
		put(mv(0, 0, 4'hC, t));
		do_reset(1'b0);
		mon_en = 1'b1;
		for (int n = 0; n < 3000 && exq.size() > 0; n++) begin
			@(negedge mclk);
		end
		repeat (20) @(negedge mclk);
		chk("pending", 32'(exq.size()), 32'h0);
		mon_en = 1'b0;
		do_reset(1'b1);
		tally_and_finish();
	end
endmodule

`default_nettype wire
